// ==== verilog/roa_pkg.sv ====
// Shared constants and types of the redundant owner arbiter.
// Assumes one 50 MHz clock shared by the device end and both owner ends.
package roa_pkg;

    // ==========================================================
    // Sides and connection status
    // ==========================================================
    localparam logic SIDE_A = 1'b0;
    localparam logic SIDE_B = 1'b1;
    localparam logic [7:0] GEN_STATUS_OK = 8'h00;
    localparam logic [7:0] GEN_STATUS_REJECT = 8'h01;
    localparam logic [15:0] EXT_STATUS_OK = 16'h0000;
    localparam logic [15:0] EXT_STATUS_PAIR = 16'h031D;

    // ==========================================================
    // Widths and timing
    // ==========================================================
    localparam int DATA_W = 16;
    localparam int CLK_HZ = 50_000_000;
    localparam int UPDATE_INTERVAL_MS = 25;
    localparam int UPDATE_CYCLES = (CLK_HZ / 1000) * UPDATE_INTERVAL_MS;

    // ==========================================================
    // Owner side register map over APB (byte addresses)
    // ==========================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_ERR = 8'h0C;
    localparam int CTRL_CONNECT = 0;
    localparam int CTRL_REQUEST = 1;
    localparam int CTRL_WILLING = 2;
    localparam int CTRL_SIDE = 3;
    localparam int CTRL_RUN = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ROA_IDLE = 3'b001,
        ROA_OPEN = 3'b010,
        ROA_LIVE = 3'b100
    } roa_conn_t;

endpackage

// ==== verilog/roa_link_if.sv ====
// Link between the arbitrating output device and its two owners.
// Assumes both ends run on the same clock; one modport per party.
`timescale 1ns/100ps
interface roa_link_if #(parameter int DW = 16);
    // Per side, index 0 is side A and index 1 is side B.
    logic [1:0] open_req;
    logic [1:0] open_side;
    logic [1:0] update;
    logic [1:0] req_bit;
    logic [1:0] will_bit;
    logic [DW-1:0] out_data_a;
    logic [DW-1:0] out_data_b;
    logic [1:0] conn_ack;
    logic [1:0] conn_rej;
    logic [7:0] gen_status;
    logic [15:0] ext_status;
    logic [1:0] link_up;
    logic [1:0] req_echo;
    logic [1:0] will_echo;
    logic has_active;
    logic active_side;

    modport device (
        input open_req, open_side, update, req_bit, will_bit,
        input out_data_a, out_data_b,
        output conn_ack, conn_rej, gen_status, ext_status,
        output link_up, req_echo, will_echo, has_active, active_side
    );
    modport owner (
        output open_req, open_side, update, req_bit, will_bit,
        output out_data_a, out_data_b,
        input conn_ack, conn_rej, gen_status, ext_status,
        input link_up, req_echo, will_echo, has_active, active_side
    );
endinterface

// ==== verilog/roa_owner.sv ====
// Owner end: two connection slots driven by software over APB.
// Assumes an APB master on the same clock; each slot is one owner path.
`timescale 1ns/100ps
module roa_owner #(
    parameter int DW = roa_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Link
    roa_link_if.owner link
);
    // ==========================================================
    // Register decode
    // ==========================================================
    logic [31:0] ctrl_a_ff;
    logic [31:0] ctrl_b_ff;
    logic [DW-1:0] data_a_ff;
    logic [DW-1:0] data_b_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [1:0] upd_ff;
    wire logic slot = paddr_i[4];
    wire logic [7:0] reg_off = {paddr_i[7:5], 1'b0, paddr_i[3:0]};
    wire logic access = psel_i && penable_i && !pready_ff;
    wire logic wr = access && pwrite_i;
    wire logic hit = (reg_off == roa_pkg::REG_CTRL) ||
        (reg_off == roa_pkg::REG_DATA) || (reg_off == roa_pkg::REG_STAT) ||
        (reg_off == roa_pkg::REG_ERR);
    wire logic [31:0] stat_word = {26'h000_0000, link.active_side,
        link.has_active, link.will_echo[slot], link.req_echo[slot],
        link.link_up[slot], link.conn_rej[slot]};
    wire logic [31:0] err_word = {8'h00, link.gen_status, link.ext_status};
    wire logic [31:0] ctrl_sel = slot ? ctrl_b_ff : ctrl_a_ff;
    wire logic [DW-1:0] data_sel = slot ? data_b_ff : data_a_ff;
    logic [31:0] rd_word;
    always_comb begin
        case (reg_off)
            roa_pkg::REG_CTRL: rd_word = ctrl_sel;
            roa_pkg::REG_DATA: rd_word = 32'(data_sel);
            roa_pkg::REG_STAT: rd_word = stat_word;
            roa_pkg::REG_ERR: rd_word = err_word;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Request and willing bits only go out while in run mode.
    function automatic logic [1:0] flags(input logic [31:0] c);
        flags = c[roa_pkg::CTRL_RUN] ?
            {c[roa_pkg::CTRL_WILLING], c[roa_pkg::CTRL_REQUEST]} : 2'b00;
    endfunction
    wire logic [1:0] fa = flags(ctrl_a_ff);
    wire logic [1:0] fb = flags(ctrl_b_ff);

    // ==========================================================
    // Registers and link drive
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_a_ff <= roa_pkg::CTRL_RESET;
            ctrl_b_ff <= roa_pkg::CTRL_RESET;
            data_a_ff <= '0;
            data_b_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            upd_ff <= 2'b00;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access && !hit;
            prdata_ff <= access ? rd_word : 32'h0000_0000;
            // Any write to a mapped register (control, data, status or error) sends a fresh update on that path.
            // Software paces these writes at its update interval.
            upd_ff <= {wr && slot && hit, wr && !slot && hit};
            if (wr && reg_off == roa_pkg::REG_CTRL && !slot)
                ctrl_a_ff <= pwdata_i;
            if (wr && reg_off == roa_pkg::REG_CTRL && slot)
                ctrl_b_ff <= pwdata_i;
            if (wr && reg_off == roa_pkg::REG_DATA && !slot)
                data_a_ff <= pwdata_i[DW-1:0];
            if (wr && reg_off == roa_pkg::REG_DATA && slot)
                data_b_ff <= pwdata_i[DW-1:0];
            // A refused path drops its flags before it is accepted.
            if (!link.link_up[0] && link.conn_rej[0]) begin
                ctrl_a_ff[roa_pkg::CTRL_REQUEST] <= 1'b0;
                ctrl_a_ff[roa_pkg::CTRL_WILLING] <= 1'b0;
            end
            if (!link.link_up[1] && link.conn_rej[1]) begin
                ctrl_b_ff[roa_pkg::CTRL_REQUEST] <= 1'b0;
                ctrl_b_ff[roa_pkg::CTRL_WILLING] <= 1'b0;
            end
        end
    end

    // Each slot has its own data image as well as its own side.
    assign link.open_req = {ctrl_b_ff[roa_pkg::CTRL_CONNECT],
        ctrl_a_ff[roa_pkg::CTRL_CONNECT]};
    assign link.open_side = {ctrl_b_ff[roa_pkg::CTRL_SIDE],
        ctrl_a_ff[roa_pkg::CTRL_SIDE]};
    // Flags are only sent once the path is up.
    assign link.req_bit = {fb[0] & link.link_up[1], fa[0] & link.link_up[0]};
    assign link.will_bit = {fb[1] & link.link_up[1], fa[1] & link.link_up[0]};
    assign link.update = upd_ff;
    assign link.out_data_a = data_a_ff;
    assign link.out_data_b = data_b_ff;
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
endmodule

// ==== verilog/roa_device.sv ====
// Device end: owner pairing, ownership arbitration and status echo.
// Assumes owners present flags as levels, sampled on update pulses.
`timescale 1ns/100ps
// Contract
// - Connections come as an A and B pair
// - Reject unpaired second connection, status 0x01/0x031D
// - Both connections carry identical configuration
// - Owner requests only after connection established
// - Both requesting: latest rising request wins
// - Only received rising edge counts as claim
// - No requests: willing side owns
// - No requests, both willing: side A
// - No flags at all: outputs idle
// - Report active owner and its side
// - Report link up and echo flags
// - Willing indication is one bit per owner
// - Unowned until requesting connection exists; code gives a willing side ownership without any request
// - Requester lost: move to willing side
// - Requester back: ownership returns to it
// - Secondary willing only after primary owns
// - Returning primary toggles request to retake
// - Secondary drops request after primary retakes
// - Owner clears flags on connection loss
// - Owner holds flags inactive until run
// - Owner update interval recommended 25 ms
module roa_device #(
    parameter int DW = roa_pkg::DATA_W,
    parameter logic [DW-1:0] IDLE_VALUE = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Link
    roa_link_if.device link,
    // Applied output
    output logic [DW-1:0] out_data_o,
    output logic out_idle_o
);
    // ==========================================================
    // Connection state per side
    // ==========================================================
    roa_pkg::roa_conn_t conn_ff [2];
    logic [1:0] rej_ff;
    logic [1:0] seen_ff;
    logic [7:0] gen_ff;
    logic [15:0] ext_ff;
    logic [1:0] req_ff;
    logic [1:0] will_ff;
    logic last_ff;
    logic own_ff;
    logic act_ff;
    logic [DW-1:0] out_ff;
    logic idle_ff;
    wire logic [1:0] up = {conn_ff[1] == roa_pkg::ROA_LIVE,
        conn_ff[0] == roa_pkg::ROA_LIVE};
    // Slot 0 must ask for side A and slot 1 for side B.
    wire logic [1:0] pair_ok = {link.open_side[1] == roa_pkg::SIDE_B,
        link.open_side[0] == roa_pkg::SIDE_A};
    wire logic [1:0] live_upd = link.update & up;
    // A slot's first live update only primes its claim history, so a
    // connection made with the request already set is no claim.
    wire logic [1:0] nxt_seen = (seen_ff | live_upd) & up;
    // Later live updates count a claim on a cleared to set change.
    wire logic [1:0] rise = live_upd & seen_ff & link.req_bit & ~req_ff;
    wire logic [1:0] nxt_req = (live_upd & link.req_bit) |
        (~live_upd & up & req_ff);
    wire logic [1:0] nxt_will = (live_upd & link.will_bit) |
        (~live_upd & up & will_ff);
    // Latest rising claim; B wins a same cycle tie as the later slot.
    wire logic nxt_last = rise[1] ? roa_pkg::SIDE_B :
        (rise[0] ? roa_pkg::SIDE_A : last_ff);

    // Arbitration over current flags; losses already clear them.
    function automatic logic [1:0] arbitrate(input logic [1:0] r,
        input logic [1:0] w, input logic last);
        // Returns {active, side}.
        if (r == 2'b11)
            arbitrate = {1'b1, last};
        else if (r[0])
            arbitrate = {1'b1, roa_pkg::SIDE_A};
        else if (r[1])
            arbitrate = {1'b1, roa_pkg::SIDE_B};
        else if (w[0])
            arbitrate = {1'b1, roa_pkg::SIDE_A};
        else if (w[1])
            arbitrate = {1'b1, roa_pkg::SIDE_B};
        else
            arbitrate = 2'b00;
    endfunction
    wire logic [1:0] nxt_arb = arbitrate(nxt_req, nxt_will, nxt_last);

    // ==========================================================
    // Connection open, reject and loss
    // ==========================================================
    // Next state of one slot; a wrong side waits, refused, in open.
    function automatic roa_pkg::roa_conn_t conn_step(
        input roa_pkg::roa_conn_t c, input logic want, input logic ok);
        case (c)
            roa_pkg::ROA_IDLE:
                conn_step = want ? roa_pkg::ROA_OPEN : roa_pkg::ROA_IDLE;
            roa_pkg::ROA_OPEN: begin
                if (!want)
                    conn_step = roa_pkg::ROA_IDLE;
                else if (ok)
                    conn_step = roa_pkg::ROA_LIVE;
                else
                    conn_step = roa_pkg::ROA_OPEN;
            end
            roa_pkg::ROA_LIVE:
                conn_step = want ? roa_pkg::ROA_LIVE : roa_pkg::ROA_IDLE;
            default:
                conn_step = roa_pkg::ROA_IDLE;
        endcase
    endfunction

    // Refusal stands while a wrong side waits and clears once closed.
    function automatic logic rej_step(input roa_pkg::roa_conn_t c,
        input logic want, input logic ok, input logic r);
        case (c)
            roa_pkg::ROA_IDLE:
                rej_step = want ? r : 1'b0;
            roa_pkg::ROA_OPEN:
                rej_step = want ? !ok : r;
            default:
                rej_step = r;
        endcase
    endfunction

    roa_pkg::roa_conn_t nxt_conn_a;
    roa_pkg::roa_conn_t nxt_conn_b;
    assign nxt_conn_a = conn_step(conn_ff[0], link.open_req[0], pair_ok[0]);
    assign nxt_conn_b = conn_step(conn_ff[1], link.open_req[1], pair_ok[1]);
    wire logic [1:0] nxt_rej = {
        rej_step(conn_ff[1], link.open_req[1], pair_ok[1], rej_ff[1]),
        rej_step(conn_ff[0], link.open_req[0], pair_ok[0], rej_ff[0])};

    // One process keeps both slots so every register has one driver.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conn_ff[0] <= roa_pkg::ROA_IDLE;
            conn_ff[1] <= roa_pkg::ROA_IDLE;
            rej_ff <= 2'b00;
        end else begin
            conn_ff[0] <= nxt_conn_a;
            conn_ff[1] <= nxt_conn_b;
            rej_ff <= nxt_rej;
        end
    end

    // ==========================================================
    // Received flags and claim history
    // ==========================================================
    // Echoes hold the last flags received on a live path.
    // A lost slot clears its echoes and claim history; last_ff still holds the latest claiming side.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            seen_ff <= 2'b00;
            req_ff <= 2'b00;
            will_ff <= 2'b00;
            last_ff <= roa_pkg::SIDE_A;
        end else begin
            seen_ff <= nxt_seen;
            req_ff <= nxt_req;
            will_ff <= nxt_will;
            last_ff <= nxt_last;
        end
    end

    // ==========================================================
    // Ownership, status and output
    // ==========================================================
    wire logic any_rej = |rej_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gen_ff <= roa_pkg::GEN_STATUS_OK;
            ext_ff <= roa_pkg::EXT_STATUS_OK;
            own_ff <= roa_pkg::SIDE_A;
            act_ff <= 1'b0;
            out_ff <= IDLE_VALUE;
            idle_ff <= 1'b1;
        end else begin
            gen_ff <= any_rej ? roa_pkg::GEN_STATUS_REJECT
                : roa_pkg::GEN_STATUS_OK;
            ext_ff <= any_rej ? roa_pkg::EXT_STATUS_PAIR
                : roa_pkg::EXT_STATUS_OK;
            act_ff <= nxt_arb[1];
            own_ff <= nxt_arb[0];
            idle_ff <= !nxt_arb[1];
            if (!nxt_arb[1])
                out_ff <= IDLE_VALUE;
            else if (nxt_arb[0] == roa_pkg::SIDE_B)
                out_ff <= link.out_data_b;
            else
                out_ff <= link.out_data_a;
        end
    end

    assign link.conn_ack = up;
    assign link.conn_rej = rej_ff;
    assign link.gen_status = gen_ff;
    assign link.ext_status = ext_ff;
    assign link.link_up = up;
    assign link.req_echo = req_ff;
    assign link.will_echo = will_ff;
    assign link.has_active = act_ff;
    assign link.active_side = own_ff;
    assign out_data_o = out_ff;
    assign out_idle_o = idle_ff;
endmodule

// ==== testbench/roa_monitor.sv ====
// Checker of the link between the owner end and the device end.
// Assumes the bench hands it the link signals and the device outputs.
`timescale 1ns/100ps
module roa_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Link and applied output
    input wire logic [1:0] open_req,
    input wire logic [1:0] open_side,
    input wire logic [1:0] conn_ack,
    input wire logic [1:0] conn_rej,
    input wire logic [7:0] gen_status,
    input wire logic [15:0] ext_status,
    input wire logic [1:0] link_up,
    input wire logic [1:0] req_echo,
    input wire logic [1:0] will_echo,
    input wire logic has_active,
    input wire logic active_side,
    input wire logic [15:0] out_data_a,
    input wire logic [15:0] out_data_b,
    input wire logic [15:0] out_data_o,
    input wire logic out_idle_o
);
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_REJ_STATUS: assert property (|conn_rej |=>
        gen_status == roa_pkg::GEN_STATUS_REJECT &&
        ext_status == roa_pkg::EXT_STATUS_PAIR)
        else $error("Refusal status missing.");
    AST_OK_STATUS: assert property (!(|conn_rej) |=>
        gen_status == roa_pkg::GEN_STATUS_OK &&
        ext_status == roa_pkg::EXT_STATUS_OK)
        else $error("Status not clear without refusal.");
    AST_ACK_LINK: assert property (conn_ack == link_up &&
        (link_up & ~$past(open_req)) == 2'b00)
        else $error("Link up without an open request.");
    AST_OPEN_A: assert property ($rose(open_req[0]) &&
        open_side[0] == roa_pkg::SIDE_A |-> ##[1:3] link_up[0])
        else $error("Side A connection not established.");
    AST_LOSS_CLEAR: assert property ($fell(link_up[0]) |=>
        !req_echo[0] && !will_echo[0])
        else $error("Echo not cleared after loss.");
    AST_BOTH_WILL: assert property ((link_up == 2'b11 &&
        req_echo == 2'b00 && will_echo == 2'b11) [*2] |->
        has_active && active_side == roa_pkg::SIDE_A)
        else $error("Both willing did not give side A.");
    AST_ONE_REQ: assert property ((((req_echo == 2'b01) ||
        (req_echo == 2'b10)) && $stable(req_echo)) [*2] |->
        has_active && active_side == req_echo[1])
        else $error("Single requester does not own.");
    AST_ONE_WILL: assert property ((req_echo == 2'b00 &&
        will_echo == 2'b10 && $stable(will_echo)) [*2] |->
        has_active && active_side == roa_pkg::SIDE_B)
        else $error("Willing side B does not own.");
    AST_NONE_IDLE: assert property ((req_echo == 2'b00 &&
        will_echo == 2'b00) [*2] |-> !has_active && out_idle_o)
        else $error("No flags but output not idle.");
    AST_APPLY: assert property ((has_active && $stable(active_side) &&
        $stable(out_data_a) && $stable(out_data_b)) [*3] |->
        out_data_o == (active_side ? out_data_b : out_data_a))
        else $error("Applied data is not the owner data.");
endmodule

// ==== testbench/test_redundant_owner_arbiter.sv ====
// Self-checking bench: APB orders to the owner end, device end opposite.
// Assumes one 50 MHz clock and a synchronous active high reset.
`timescale 1ns/100ps
module test_redundant_owner_arbiter;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [15:0] dev_data;
    logic dev_idle;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    roa_link_if #(.DW(16)) link ();
    roa_owner u_roa_owner (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link));
    roa_device u_roa_device (.clk_i(clk_i), .reset_i(reset_i),
        .link(link), .out_data_o(dev_data), .out_idle_o(dev_idle));
    roa_monitor u_roa_monitor (.clk_i(clk_i), .reset_i(reset_i),
        .open_req(link.open_req), .open_side(link.open_side),
        .conn_ack(link.conn_ack), .conn_rej(link.conn_rej),
        .gen_status(link.gen_status), .ext_status(link.ext_status),
        .link_up(link.link_up), .req_echo(link.req_echo),
        .will_echo(link.will_echo), .has_active(link.has_active),
        .active_side(link.active_side), .out_data_a(link.out_data_a),
        .out_data_b(link.out_data_b), .out_data_o(dev_data),
        .out_idle_o(dev_idle));

    always #10 clk_i = ~clk_i;

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(q, exp);
    endtask

    // Each order is sent twice: the first may land before the link is live.
    task automatic ctrl(input logic slot, input logic [4:0] v);
        logic [31:0] q;
        logic e;
        repeat (2) begin
            apb(1'b1, {3'h0, slot, 4'h0}, {27'h000_0000, v}, q, e);
            repeat (8) @(posedge clk_i);
        end
    endtask

    function automatic logic [4:0] mk(input logic r, w, s);
        return {1'b1, s, w, r, 1'b1};
    endfunction

    task automatic own(input logic idle, act, side, input logic [15:0] d);
        check({13'h0000, dev_idle, link.has_active, link.active_side,
            dev_data}, {13'h0000, idle, act, side, d});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd(8'h08, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000);
        own(1'b1, 1'b0, 1'b0, 16'h0000);
        apb(1'b0, 8'h40, 32'h0000_0000, q, e);
        check({q[30:0], e}, 32'h0000_0001);
        $display("reset test done");
    endtask

    task automatic t_pair();
        logic [31:0] q;
        logic e;
        apb(1'b1, 8'h04, 32'h0000_1111, q, e);
        apb(1'b1, 8'h14, 32'h0000_2222, q, e);
        ctrl(1'b1, mk(1'b0, 1'b0, roa_pkg::SIDE_A));
        rd(8'h18, 32'h0000_0001);
        rd(8'h1C, 32'h0001_031D);
        ctrl(1'b1, 5'h00);
        ctrl(1'b0, mk(1'b0, 1'b0, roa_pkg::SIDE_A));
        ctrl(1'b1, mk(1'b0, 1'b0, roa_pkg::SIDE_B));
        rd(8'h08, 32'h0000_0002);
        rd(8'h18, 32'h0000_0002);
        rd(8'h0C, 32'h0000_0000);
        own(1'b1, 1'b0, 1'b0, 16'h0000);
        $display("pairing test done");
    endtask

    task automatic t_will();
        ctrl(1'b0, mk(1'b0, 1'b1, roa_pkg::SIDE_A));
        ctrl(1'b1, mk(1'b0, 1'b1, roa_pkg::SIDE_B));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        ctrl(1'b0, mk(1'b0, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_B, 16'h2222);
        rd(8'h18, 32'h0000_003A);
        ctrl(1'b1, mk(1'b0, 1'b0, roa_pkg::SIDE_B));
        check({30'h0000_0000, dev_idle, link.has_active},
            32'h0000_0002);
        $display("standby test done");
    endtask

    task automatic t_claim();
        ctrl(1'b0, mk(1'b1, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        ctrl(1'b1, mk(1'b1, 1'b0, roa_pkg::SIDE_B));
        own(1'b0, 1'b1, roa_pkg::SIDE_B, 16'h2222);
        ctrl(1'b0, mk(1'b0, 1'b0, roa_pkg::SIDE_A));
        ctrl(1'b0, mk(1'b1, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        ctrl(1'b1, mk(1'b0, 1'b1, roa_pkg::SIDE_B));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        rd(8'h08, 32'h0000_0016);
        $display("claim test done");
    endtask

    task automatic t_loss();
        ctrl(1'b0, 5'h00);
        own(1'b0, 1'b1, roa_pkg::SIDE_B, 16'h2222);
        rd(8'h08, 32'h0000_0030);
        ctrl(1'b0, mk(1'b1, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        ctrl(1'b1, mk(1'b1, 1'b0, roa_pkg::SIDE_B));
        own(1'b0, 1'b1, roa_pkg::SIDE_B, 16'h2222);
        ctrl(1'b0, 5'h00);
        // A reconnect with the request already set is no new claim.
        ctrl(1'b0, mk(1'b1, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_B, 16'h2222);
        ctrl(1'b0, mk(1'b0, 1'b0, roa_pkg::SIDE_A));
        ctrl(1'b0, mk(1'b1, 1'b0, roa_pkg::SIDE_A));
        own(1'b0, 1'b1, roa_pkg::SIDE_A, 16'h1111);
        $display("loss test done");
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_pair();
        t_will();
        t_claim();
        t_loss();
        wrap_up();
    end
endmodule
